// ### akei_pkg.sv
// shared constants and types for the accessory key event block
// assumes a 20 MHz system clock on both ends of the serial link
package akei_pkg;
	localparam int CLK_NS = 50;
	localparam int HOLD_NS = 30_000_000;
	localparam int HOLD_CYC = HOLD_NS / CLK_NS;
	localparam int LONG_STEP_NS = 100_000_000;
	localparam int LONG_STEP_CYC = LONG_STEP_NS / CLK_NS;
	localparam int SCL_PERIOD_NS = 10_000;
	localparam int PHASE_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
	// target address and id value are arbitrary
	localparam logic [6:0] TGT_ADDR = 7'h25;
	localparam logic [7:0] DEV_ID_VAL = 8'h11;
	localparam logic [7:0] SYNC_RST = 8'hdf;
	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] REG_FIRST = 8'h01;
	localparam logic [7:0] REG_CTRL = 8'h02;
	localparam logic [7:0] REG_INT1 = 8'h03;
	localparam logic [7:0] REG_INT2 = 8'h04;
	localparam logic [7:0] REG_MASK1 = 8'h05;
	localparam logic [7:0] REG_MASK2 = 8'h06;
	localparam logic [7:0] REG_ADC = 8'h07;
	localparam logic [7:0] REG_TIME1 = 8'h08;
	localparam logic [7:0] REG_TIME2 = 8'h09;
	localparam logic [7:0] REG_DTYPE1 = 8'h0a;
	localparam logic [7:0] REG_DTYPE2 = 8'h0b;
	localparam logic [7:0] REG_BTN1 = 8'h0c;
	localparam logic [7:0] REG_BTN2 = 8'h0d;
	localparam logic [7:0] REG_LAST = 8'h14;
	localparam logic [4:0] CTRL_RST = 5'h1f;
	localparam int CTRL_INT_MASK = 0;
	localparam int INT1_ATTACH = 0;
	localparam int INT1_DETACH = 1;
	localparam int INT1_KP = 2;
	localparam int INT1_LKP = 3;
	localparam int INT1_LKR = 4;
	localparam int INT2_SK = 3;
	localparam int INT2_SKR = 4;
	localparam int BTN_ERROR = 13;
	localparam int DT1_OTG = 7;
	localparam int DT1_AUDIO1 = 0;
	////////////////////////////////////////////////////////////////////
	localparam logic [4:0] ID_OTG = 5'h00;
	localparam logic [4:0] ID_SEND_END = 5'h01;
	localparam logic [4:0] ID_KEY_LAST = 5'h0d;
	localparam logic [4:0] ID_USB_OFF = 5'h18;
	localparam logic [4:0] ID_USB_ON = 5'h19;
	localparam logic [4:0] ID_UART_OFF = 5'h1c;
	localparam logic [4:0] ID_UART_ON = 5'h1d;
	localparam logic [4:0] ID_HEADSET = 5'h1e;
	localparam logic [4:0] ID_NONE = 5'h1f;
	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] H_REG_CTRL = 8'h00;
	localparam logic [7:0] H_REG_SUB = 8'h01;
	localparam logic [7:0] H_REG_WDATA = 8'h02;
	localparam logic [7:0] H_REG_STATUS = 8'h03;
	localparam logic [7:0] H_REG_RDATA = 8'h04;
	localparam int HC_GO = 0;
	localparam int HC_READ = 1;
	typedef enum logic [2:0] {I_IDLE, I_RX, I_RX_ACK, I_TX, I_TX_ACK}
		akei_link_type;
	typedef enum logic [1:0] {RX_ADDR, RX_SUB, RX_DATA} akei_rx_type;
	typedef enum logic [2:0] {K_IDLE, K_PRESS, K_LONG, K_STUCK, K_HELD}
		akei_key_type;
	typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP}
		akei_op_type;
endpackage

// ### akei_if.sv
// two-wire link between the host controller and the key event device
// sda is open drain: the level is low when either end drives low
`timescale 1ns/10ps
`default_nettype none
interface akei_if;
	logic scl;
	logic sda;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic irq_out_n;
	assign sda = !((!host_sda_oe_n && !host_sda_out) ||
		(!dev_sda_oe_n && !dev_sda_out));
	modport device (
		input scl, sda,
		output dev_sda_out, dev_sda_oe_n, irq_out_n
	);
	modport host (
		output scl, host_sda_out, host_sda_oe_n,
		input sda, irq_out_n
	);
endinterface
`default_nettype wire

// ### akei_device.sv
// accessory key event logic with its two-wire register target
// assumes id code and attach level come from the analog front end
// Functional notes
// - short release of unknown key: short flag, error bit
// - short release of known key: short flag, key bit
// - reading interrupt status clears reported flag
// - key held to long time: long flag
// - release after long press: long-release flag
// - key held at attach to long time: stuck
// - stuck then headset code: stuck-release flag
// - send/end code 1, keys 1-12 codes 2-13
// - headset 11110, nothing 11111, on-the-go 00000
// - factory cables coded 11000,11001,11100,11101
// - start and stop framed while clock high
// - address msb first, acknowledged on match
// - general call address never acknowledged
// - write direction zero, every data byte acknowledged
// - only whole acknowledged bytes take effect
// - one bit per clock, data stable while high
// - any byte count, one ack slot each
// - transmitter releases data line for ack
// - receiver holds ack low through clock high
// - controller starts only on idle bus; the host starts on a go write without sensing the bus
// - acknowledged read resets interrupt register; the code also clears it after a nacked read
// - both lines low 30 ms resets logic
// - burst address wraps 14h to 01h
`timescale 1ns/10ps
`default_nettype none
module akei_device import akei_pkg::*; #(
	parameter int P_HOLD_CYC = HOLD_CYC,
	parameter int P_LONG_CYC = LONG_STEP_CYC
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	akei_if.device link,
	input wire logic i_attached,
	input wire logic [4:0] i_id_code,
	output logic o_soft_reset
);
	logic [7:0] s1_q, s2_q, s3_q, f_q, p_q, f_d;
	logic scl, sda, att, scl_rise, scl_fall, start, stop;
	logic att_rise, att_fall, soft_rst;
	logic [4:0] code;
	logic [19:0] hold_q;
	////////////////////////////////////////////////////////////////////
	// three stage sampling; a bit moves only when stages two and three agree
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
			f_q <= SYNC_RST;
			p_q <= SYNC_RST;
		end else begin
			s1_q <= {link.scl, link.sda, i_attached, i_id_code};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= f_d;
			p_q <= f_q;
		end
	end
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_filt
			assign f_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : f_q[g];
		end
	endgenerate
	assign scl = f_q[7];
	assign sda = f_q[6];
	assign att = f_q[5];
	assign code = f_q[4:0];
	assign scl_rise = scl && !p_q[7];
	assign scl_fall = !scl && p_q[7];
	assign start = scl && p_q[7] && p_q[6] && !sda;
	assign stop = scl && p_q[7] && !p_q[6] && sda;
	assign att_rise = att && !p_q[5];
	assign att_fall = !att && p_q[5];
	////////////////////////////////////////////////////////////////////
	// bus hold reset fires once per low period
	assign soft_rst = !scl && !sda && hold_q == 20'(P_HOLD_CYC - 1);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_q <= 20'h0;
		end else if (scl || sda) begin
			hold_q <= 20'h0;
		end else if (hold_q != 20'(P_HOLD_CYC)) begin
			hold_q <= hold_q + 20'h1;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= soft_rst;
		end
	end
	////////////////////////////////////////////////////////////////////
	akei_link_type st_q;
	akei_rx_type kind_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, ptr_q, nxt_ptr, rd_addr, rd_data;
	logic rw_q, drive_q, mack_q, wr, rd_clr;
	assign nxt_ptr = (ptr_q == REG_LAST) ? REG_FIRST : ptr_q + 8'h01;
	assign rd_addr = (st_q == I_TX_ACK) ? nxt_ptr : ptr_q;
	// register writes only after the acknowledge slot has ended
	assign wr = st_q == I_RX_ACK && scl_fall && kind_q == RX_DATA;
	// a closing nack still clears: a single-byte read always ends in one
	assign rd_clr = st_q == I_TX_ACK && scl_fall;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= I_IDLE;
			kind_q <= RX_ADDR;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= REG_FIRST;
			rw_q <= 1'b0;
			drive_q <= 1'b0;
			mack_q <= 1'b0;
		end else if (soft_rst || stop) begin
			st_q <= I_IDLE;
			drive_q <= 1'b0;
		end else if (start) begin
			st_q <= I_RX;
			kind_q <= RX_ADDR;
			bit_q <= 4'h0;
			drive_q <= 1'b0;
		end else begin
			case (st_q)
			I_RX: begin
				if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda};
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					if (kind_q != RX_ADDR) begin
						drive_q <= 1'b1;
						st_q <= I_RX_ACK;
					end else if (sh_q[7:1] == TGT_ADDR &&
						sh_q[7:1] != 7'h00) begin
						rw_q <= sh_q[0];
						drive_q <= 1'b1;
						st_q <= I_RX_ACK;
					end else begin
						st_q <= I_IDLE;
					end
				end
			end
			I_RX_ACK: begin
				// ack held low until the falling clock ends the slot
				if (scl_fall) begin
					bit_q <= 4'h0;
					drive_q <= 1'b0;
					st_q <= I_RX;
					if (kind_q == RX_ADDR && rw_q) begin
						sh_q <= rd_data;
						drive_q <= !rd_data[7];
						st_q <= I_TX;
					end else if (kind_q == RX_ADDR) begin
						kind_q <= RX_SUB;
					end else if (kind_q == RX_SUB) begin
						ptr_q <= sh_q;
						kind_q <= RX_DATA;
					end else begin
						ptr_q <= nxt_ptr;
					end
				end
			end
			I_TX: begin
				if (scl_rise) begin
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					drive_q <= 1'b0;
					st_q <= I_TX_ACK;
				end else if (scl_fall) begin
					sh_q <= {sh_q[6:0], 1'b0};
					drive_q <= !sh_q[6];
				end
			end
			I_TX_ACK: begin
				if (scl_rise) begin
					mack_q <= !sda;
				end else if (scl_fall && mack_q) begin
					ptr_q <= nxt_ptr;
					sh_q <= rd_data;
					drive_q <= !rd_data[7];
					bit_q <= 4'h0;
					st_q <= I_TX;
				end else if (scl_fall) begin
					st_q <= I_IDLE;
				end
			end
			default: st_q <= I_IDLE;
			endcase
		end
	end
	assign link.dev_sda_out = 1'b0;
	assign link.dev_sda_oe_n = !drive_q;
	////////////////////////////////////////////////////////////////////
	akei_key_type k_q, k_d;
	logic [21:0] cnt_q;
	logic [3:0] stp_q;
	logic [4:0] key_q;
	logic [7:0] time2_q;
	logic pressed, key_ok, tick, reached, btn_ld;
	logic ev_kp, ev_lkp, ev_lkr, ev_sk, ev_skr;
	logic [15:0] btn_v;
	assign pressed = att && code != ID_HEADSET && code != ID_NONE &&
		code != ID_OTG;
	assign key_ok = key_q >= ID_SEND_END && key_q <= ID_KEY_LAST;
	assign tick = cnt_q == 22'(P_LONG_CYC - 1);
	assign reached = tick && stp_q == time2_q[3:0];
	always_comb begin
		k_d = k_q;
		ev_kp = 1'b0;
		ev_lkp = 1'b0;
		ev_lkr = 1'b0;
		ev_sk = 1'b0;
		ev_skr = 1'b0;
		btn_ld = 1'b0;
		btn_v = 16'h0001 << (key_q - ID_SEND_END);
		case (k_q)
		K_IDLE: begin
			if (att_rise && pressed) begin
				k_d = K_STUCK;
			end else if (att && pressed) begin
				k_d = K_PRESS;
			end
		end
		K_PRESS: begin
			if (!pressed) begin
				ev_kp = 1'b1;
				btn_ld = 1'b1;
				if (!key_ok) begin
					btn_v = 16'h0001 << BTN_ERROR;
				end
				k_d = K_IDLE;
			end else if (reached) begin
				ev_lkp = 1'b1;
				btn_ld = 1'b1;
				k_d = K_LONG;
			end
		end
		K_LONG: begin
			if (!pressed) begin
				ev_lkr = 1'b1;
				k_d = K_IDLE;
			end
		end
		K_STUCK: begin
			if (!pressed) begin
				k_d = K_IDLE;
			end else if (reached) begin
				ev_sk = 1'b1;
				btn_ld = 1'b1;
				k_d = K_HELD;
			end
		end
		K_HELD: begin
			if (att && code == ID_HEADSET) begin
				ev_skr = 1'b1;
				k_d = K_IDLE;
			end else if (!att) begin
				k_d = K_IDLE;
			end
		end
		default: k_d = K_IDLE;
		endcase
	end
	// key code is latched while idle so the release value never leaks in
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			k_q <= K_IDLE;
			cnt_q <= 22'h0;
			stp_q <= 4'h0;
			key_q <= ID_NONE;
		end else if (soft_rst) begin
			k_q <= K_IDLE;
		end else begin
			k_q <= k_d;
			if (k_q == K_IDLE || k_q != k_d) begin
				cnt_q <= 22'h0;
				stp_q <= 4'h0;
			end else if (tick) begin
				cnt_q <= 22'h0;
				stp_q <= stp_q + 4'h1;
			end else begin
				cnt_q <= cnt_q + 22'h1;
			end
			if (k_q == K_IDLE) begin
				key_q <= code;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	logic [4:0] ctrl_q;
	logic [7:0] int1_q, int2_q, mask1_q, mask2_q, time1_q, set1, set2;
	logic [7:0] dt1, dt2;
	logic [15:0] btn_q;
	logic hold_irq_q, irq_q;
	always_comb begin
		set1 = 8'h00;
		set2 = 8'h00;
		set1[INT1_ATTACH] = att_rise;
		set1[INT1_DETACH] = att_fall;
		set1[INT1_KP] = ev_kp;
		set1[INT1_LKP] = ev_lkp;
		set1[INT1_LKR] = ev_lkr;
		set2[INT2_SK] = ev_sk;
		set2[INT2_SKR] = ev_skr;
		dt1 = 8'h00;
		dt1[DT1_OTG] = att && code == ID_OTG;
		dt1[DT1_AUDIO1] = att && code == ID_HEADSET;
		dt2 = {4'h0, code == ID_UART_OFF, code == ID_UART_ON,
			code == ID_USB_OFF, code == ID_USB_ON};
	end
	// new events win over a clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= CTRL_RST;
			int1_q <= 8'h00;
			int2_q <= 8'h00;
			mask1_q <= 8'h00;
			mask2_q <= 8'h00;
			time1_q <= 8'h00;
			time2_q <= 8'h00;
			btn_q <= 16'h0;
		end else if (soft_rst) begin
			ctrl_q <= CTRL_RST;
			int1_q <= 8'h00;
			int2_q <= 8'h00;
			mask1_q <= 8'h00;
			mask2_q <= 8'h00;
			time1_q <= 8'h00;
			time2_q <= 8'h00;
			btn_q <= 16'h0;
		end else begin
			if (wr && ptr_q == REG_CTRL) begin
				ctrl_q <= sh_q[4:0];
			end else if (wr && ptr_q == REG_MASK1) begin
				mask1_q <= sh_q;
			end else if (wr && ptr_q == REG_MASK2) begin
				mask2_q <= sh_q;
			end else if (wr && ptr_q == REG_TIME1) begin
				time1_q <= sh_q;
			end else if (wr && ptr_q == REG_TIME2) begin
				time2_q <= sh_q;
			end
			int1_q <= ((rd_clr && ptr_q == REG_INT1) ? 8'h00 : int1_q) |
				set1;
			int2_q <= ((rd_clr && ptr_q == REG_INT2) ? 8'h00 : int2_q) |
				set2;
			if (btn_ld) begin
				btn_q <= btn_v;
			end
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_irq_q <= 1'b0;
			irq_q <= 1'b1;
		end else begin
			if (soft_rst) begin
				hold_irq_q <= 1'b1;
			end else if (wr && ptr_q == REG_CTRL && !sh_q[CTRL_INT_MASK]) begin
				hold_irq_q <= 1'b0;
			end
			irq_q <= !(hold_irq_q || (!ctrl_q[CTRL_INT_MASK] &&
				(|(int1_q & ~mask1_q) || |(int2_q & ~mask2_q))));
		end
	end
	assign link.irq_out_n = irq_q;
	always_comb begin
		if (rd_addr == REG_FIRST) begin
			rd_data = DEV_ID_VAL;
		end else if (rd_addr == REG_CTRL) begin
			rd_data = {3'h0, ctrl_q};
		end else if (rd_addr == REG_INT1) begin
			rd_data = int1_q;
		end else if (rd_addr == REG_INT2) begin
			rd_data = int2_q;
		end else if (rd_addr == REG_MASK1) begin
			rd_data = mask1_q;
		end else if (rd_addr == REG_MASK2) begin
			rd_data = mask2_q;
		end else if (rd_addr == REG_ADC) begin
			rd_data = {3'h0, code};
		end else if (rd_addr == REG_TIME1) begin
			rd_data = time1_q;
		end else if (rd_addr == REG_TIME2) begin
			rd_data = time2_q;
		end else if (rd_addr == REG_DTYPE1) begin
			rd_data = dt1;
		end else if (rd_addr == REG_DTYPE2) begin
			rd_data = dt2;
		end else if (rd_addr == REG_BTN1) begin
			rd_data = btn_q[7:0];
		end else if (rd_addr == REG_BTN2) begin
			rd_data = btn_q[15:8];
		end else begin
			rd_data = 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### akei_host.sv
// host controller end: runs one register write or read on the link
// assumes software drives the plain command port on the same clock
`timescale 1ns/10ps
`default_nettype none
module akei_host import akei_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	akei_if.host link,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata
);
	logic [1:0] s1_q, s2_q, s3_q, f_q;
	logic [7:0] sub_q, wd_q, rx_q, cur;
	logic [5:0] pc_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [2:0] step_q;
	logic busy_q, rd_q, nack_q, scl_q, low_q, tick, last_bit;
	akei_op_type op;
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
			f_q <= 2'h3;
		end else begin
			s1_q <= {link.sda, link.irq_out_n};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
		end
	end
	////////////////////////////////////////////////////////////////////
	// sequence: start, address, sub address, then data or restart path
	always_comb begin
		op = OP_TX;
		cur = {TGT_ADDR, 1'b0};
		if (step_q == 3'h0 || (rd_q && step_q == 3'h3)) begin
			op = OP_START;
		end else if (step_q == 3'h2) begin
			cur = sub_q;
		end else if (!rd_q && step_q == 3'h3) begin
			cur = wd_q;
		end else if (rd_q && step_q == 3'h4) begin
			cur = {TGT_ADDR, 1'b1};
		end else if (rd_q && step_q == 3'h5) begin
			op = OP_RX;
		end else if (step_q != 3'h1) begin
			op = OP_STOP;
		end
	end
	assign tick = pc_q == 6'(PHASE_CYC - 1);
	assign last_bit = bit_q == 4'h8;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pc_q <= 6'h0;
		end else if (!busy_q || tick) begin
			pc_q <= 6'h0;
		end else begin
			pc_q <= pc_q + 6'h1;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			rd_q <= 1'b0;
			nack_q <= 1'b0;
			step_q <= 3'h0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			scl_q <= 1'b1;
			low_q <= 1'b0;
			rx_q <= 8'h00;
		end else if (!busy_q) begin
			if (i_wr && i_addr == H_REG_CTRL && i_wdata[HC_GO]) begin
				busy_q <= 1'b1;
				rd_q <= i_wdata[HC_READ];
				nack_q <= 1'b0;
				step_q <= 3'h0;
				ph_q <= 2'h0;
				bit_q <= 4'h0;
			end
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
			case (op)
			OP_START: begin
				if (ph_q == 2'h0) begin
					low_q <= 1'b0;
				end else if (ph_q == 2'h1) begin
					scl_q <= 1'b1;
				end else if (ph_q == 2'h2) begin
					low_q <= 1'b1;
				end else begin
					scl_q <= 1'b0;
					step_q <= step_q + 3'h1;
				end
			end
			OP_STOP: begin
				if (ph_q == 2'h0) begin
					scl_q <= 1'b0;
					low_q <= 1'b1;
				end else if (ph_q == 2'h1) begin
					scl_q <= 1'b1;
				end else if (ph_q == 2'h2) begin
					low_q <= 1'b0;
				end else begin
					busy_q <= 1'b0;
				end
			end
			default: begin
				if (ph_q == 2'h0) begin
					// data changes only while the clock is low
					low_q <= op == OP_TX && !last_bit &&
						!cur[3'(4'h7 - bit_q)];
				end else if (ph_q == 2'h1) begin
					scl_q <= 1'b1;
				end else if (ph_q == 2'h2) begin
					if (op == OP_RX && !last_bit) begin
						rx_q <= {rx_q[6:0], f_q[1]};
					end else if (op == OP_TX && last_bit && f_q[1]) begin
						nack_q <= 1'b1;
					end
				end else begin
					scl_q <= 1'b0;
					bit_q <= last_bit ? 4'h0 : bit_q + 4'h1;
					if (last_bit && nack_q) begin
						step_q <= rd_q ? 3'h6 : 3'h4;
					end else if (last_bit) begin
						step_q <= step_q + 3'h1;
					end
				end
			end
			endcase
		end
	end
	// ack slot and the final read byte's nack leave the line released
	assign link.host_sda_out = 1'b0;
	assign link.host_sda_oe_n = !low_q;
	assign link.scl = scl_q;
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sub_q <= 8'h00;
			wd_q <= 8'h00;
			o_rdata <= 8'h00;
		end else begin
			if (i_wr && i_addr == H_REG_SUB) begin
				sub_q <= i_wdata;
			end else if (i_wr && i_addr == H_REG_WDATA) begin
				wd_q <= i_wdata;
			end
			if (!i_rd) begin
				o_rdata <= 8'h00;
			end else if (i_addr == H_REG_SUB) begin
				o_rdata <= sub_q;
			end else if (i_addr == H_REG_WDATA) begin
				o_rdata <= wd_q;
			end else if (i_addr == H_REG_STATUS) begin
				o_rdata <= {5'h0, !f_q[0], nack_q, busy_q};
			end else if (i_addr == H_REG_RDATA) begin
				o_rdata <= rx_q;
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// ### akei_props.sv
// link protocol checks for the key event block
// assumes it sits beside the interface on the device clock
`timescale 1ns/10ps
`default_nettype none
module akei_props import akei_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic irq_out_n
);
	logic [3:0] bits_q;
	logic [7:0] sh_q;
	logic first_q, rw_q, ack_q, need_q;
	logic [4:0] since_q;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////
	// tracks bit position inside each byte so ack slots are known
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bits_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			need_q <= 1'b0;
		end else if (scl && $fell(sda)) begin
			bits_q <= 4'h0;
			first_q <= 1'b1;
			ack_q <= 1'b0;
		end else if ($rose(scl) && bits_q == 4'h8) begin
			bits_q <= 4'h0;
			first_q <= 1'b0;
			ack_q <= 1'b1;
			need_q <= first_q ? sh_q[7:1] == TGT_ADDR : !rw_q;
			rw_q <= first_q ? sh_q[0] : rw_q;
		end else if ($rose(scl)) begin
			bits_q <= bits_q + 4'h1;
			sh_q <= {sh_q[6:0], sda};
		end else if ($fell(scl)) begin
			ack_q <= 1'b0;
		end
	end
	// cycles since an ack slot ended; saturates so it never wraps
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			since_q <= 5'h1f;
		end else if ($fell(scl) && ack_q) begin
			since_q <= 5'h00;
		end else if (since_q != 5'h1f) begin
			since_q <= since_q + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	sequence ack_rise;
		$rose(scl) && bits_q == 4'h8;
	endsequence
	dev_stable_a: assert property (scl && $past(scl) |->
		dev_sda_oe_n == $past(dev_sda_oe_n)) else $error("device moved sda");
	start_rel_a: assert property (scl && $fell(sda) |-> dev_sda_oe_n)
		else $error("device drives at start");
	addr_msb_a: assert property (ack_rise ##0 first_q |->
		sh_q[7:1] == TGT_ADDR) else $error("address bits wrong");
	addr_ack_a: assert property (ack_rise ##0
		(first_q && sh_q[7:1] == TGT_ADDR) |-> !sda) else $error("no addr ack");
	data_ack_a: assert property (ack_rise ##0 (!first_q && !rw_q) |->
		!sda && !dev_sda_oe_n) else $error("data byte not acked");
	host_rel_a: assert property (ack_rise ##0 (first_q || !rw_q) |->
		host_sda_oe_n) else $error("host holds sda in ack");
	dev_rel_a: assert property (ack_rise ##0 (!first_q && rw_q) |->
		dev_sda_oe_n) else $error("device holds sda in ack");
	ack_hold_a: assert property ($fell(scl) && ack_q && need_q |->
		!$past(sda)) else $error("ack dropped while scl high");
	irq_rise_a: assert property ($rose(irq_out_n) |-> since_q < 5'h10)
		else $error("irq released without a read");
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench: host and device ends joined by the link
// assumes host port read data stands one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module tb_top import akei_pkg::*;;
	logic clk, rst_n, wr_s, rd_s, att, srst;
	logic srst_seen = 1'b0;
	logic [7:0] addr, wdata, rdata, v;
	logic [4:0] code;
	int bad_count, cmp_count;
	akei_if link();
	akei_host akei_host_i (.i_clock(clk), .i_rst_n(rst_n), .link(link),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata));
	// short counts keep long-press and bus-hold times inside the run;
	// the hold count must outlast a 100-cycle clock low with data low
	akei_device #(.P_HOLD_CYC(400), .P_LONG_CYC(20)) akei_device_i (
		.i_clock(clk), .i_rst_n(rst_n), .link(link), .i_attached(att),
		.i_id_code(code), .o_soft_reset(srst));
	akei_props akei_props_i (.i_clock(clk), .i_rst_n(rst_n),
		.scl(link.scl), .sda(link.sda), .host_sda_oe_n(link.host_sda_oe_n),
		.dev_sda_oe_n(link.dev_sda_oe_n), .irq_out_n(link.irq_out_n));
	// normal traffic must never look like a bus hold
	always @(posedge clk) begin
		if (srst) begin
			srst_seen <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// one link transaction; busy is polled with a bounded count
	task automatic xfer(input logic [7:0] s, d, input logic r);
		logic [7:0] st;
		wr(H_REG_SUB, s);
		wr(H_REG_WDATA, d);
		wr(H_REG_CTRL, {6'h00, r, 1'b1});
		st = 8'h01;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 9000 && st[0] !== 1'b0; i++) rd(H_REG_STATUS, st);
		chk("status", st & 8'h03, 8'h00);
	endtask
	task automatic hget(input logic [7:0] s, output logic [7:0] d);
		xfer(s, 8'h00, 1'b1);
		rd(H_REG_RDATA, d);
	endtask
	task automatic irq(input logic e);
		chk("irq_out_n", {7'h00, link.irq_out_n}, {7'h00, e});
	endtask
	task automatic press(input logic [4:0] c, input int n);
		@(posedge clk);
		code <= c;
		repeat (n) @(posedge clk);
		code <= ID_HEADSET;
		repeat (20) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#5_400_000;
		bad_count++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		{wr_s, rd_s, addr, wdata} = 18'h00000;
		att = 1'b1;
		code = ID_HEADSET;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		xfer(REG_CTRL, 8'h1e, 1'b0);
		// long-press time becomes 16 steps of 20 cycles
		xfer(REG_TIME2, 8'h0f, 1'b0);
		hget(REG_INT1, v);
		chk("int1 attach", v, 8'h01);
		irq(1'b1);
		press(ID_SEND_END + 5'h01, 100);
		irq(1'b0);
		hget(REG_BTN1, v);
		chk("btn1 short", v, 8'h02);
		press(5'h0e, 100);
		hget(REG_BTN2, v);
		chk("btn2 error", v, 8'h20);
		hget(REG_INT1, v);
		chk("int1 short", v, 8'h04);
		code <= ID_SEND_END;
		repeat (400) @(posedge clk);
		irq(1'b0);
		hget(REG_INT1, v);
		chk("int1 long", v, 8'h08);
		code <= ID_HEADSET;
		repeat (20) @(posedge clk);
		irq(1'b0);
		hget(REG_INT1, v);
		chk("int1 release", v, 8'h10);
		att <= 1'b0;
		repeat (20) @(posedge clk);
		code <= 5'h03;
		repeat (20) @(posedge clk);
		att <= 1'b1;
		repeat (400) @(posedge clk);
		hget(REG_INT2, v);
		chk("int2 stuck", v, 8'h08);
		hget(REG_BTN1, v);
		chk("btn1 stuck", v, 8'h04);
		code <= ID_HEADSET;
		repeat (20) @(posedge clk);
		irq(1'b0);
		hget(REG_INT2, v);
		chk("int2 stuck release", v, 8'h10);
		irq(1'b0);
		hget(REG_ADC, v);
		chk("adc headset", v, {3'h0, ID_HEADSET});
		code <= ID_UART_OFF;
		repeat (20) @(posedge clk);
		hget(REG_DTYPE2, v);
		chk("dtype2 uart", v, 8'h08);
		chk("soft reset", {7'h00, srst_seen}, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
